// ===== tb_top.sv
// Self-checking bench for the voltage setpoint and soft limit block.
// Assumes a shortened millisecond count; expectations queued by drivers.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int unsigned CYC = 4;
    logic clk = 1'b0, srst = 1'b1, err_clear = 1'b0, ext_ctrl = 1'b0, meas_valid = 1'b0;
    logic cmd_valid, cmd_ready, rsp_valid, err_pulse, refresh, tracking, set_d = 1'b0, bad;
    logic [3:0] cmd_code, rsp_code;
    logic [7:0] err_ev;
    logic [31:0] setpoint;
    logic signed [31:0] cmd_value, rsp_value, meas_mv = 32'sh0, uv, ev, sp;
    logic [35:0] rsp_q[$];
    logic err_q[$];
    int error_cnt = 0, n_checks = 0, cyc = 0, n;

    always #12.5 clk = ~clk;

    vsl_core #(.CYC_PER_MS(CYC)) vsl_core_i (.ref_clk_i(clk), .srst_i(srst),
        .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .cmd_value_i(cmd_value),
        .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid), .rsp_code_o(rsp_code),
        .rsp_value_o(rsp_value), .err_pulse_o(err_pulse), .err_clear_i(err_clear),
        .cmd_error_events_o(err_ev), .ext_volt_ctrl_i(ext_ctrl), .meas_valid_i(meas_valid),
        .meas_mv_i(meas_mv), .display_refresh_o(refresh), .volt_setpoint_o(setpoint),
        .extreme_tracking_o(tracking));
    vsl_host_model vsl_host_model_i (.ref_clk_i(clk), .cmd_ready_i(cmd_ready),
        .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code), .cmd_value_o(cmd_value));

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Query with expected answer; alias answers in upper-limit form
    task automatic q(input logic [3:0] code, input logic signed [31:0] v);
        rsp_q.push_back({(code == vsl_pkg::CMD_Q_ALIAS) ? vsl_pkg::CMD_Q_UPPER : code, v});
        vsl_host_model_i.send(code, 32'sh0);
    endtask
    // Set command with expected reject flag
    task automatic s(input logic [3:0] code, input logic signed [31:0] v, input logic b);
        err_q.push_back(b);
        vsl_host_model_i.send(code, v);
    endtask
    // One measurement strobe; the line is scrambled afterwards
    task automatic meas(input logic signed [31:0] v);
        vsl_host_model_i.idle();
        meas_valid = 1'b1;
        meas_mv = v;
        @(negedge clk);
        meas_valid = 1'b0;
        meas_mv = ~v;
    endtask

    // Marks a set command taken at this edge
    always @(posedge clk)
        set_d <= cmd_valid && cmd_ready && cmd_code >= 4'h1 && cmd_code <= 4'h4;
    // Watcher: compares settled answers and reject pulses against the oldest notes
    always @(negedge clk) begin
        if (set_d) check(err_pulse, (err_q.size() > 0) ? err_q.pop_front() : 1'bx);
        if (rsp_valid === 1'b1)
            check({rsp_code, rsp_value}, (rsp_q.size() > 0) ? rsp_q.pop_front() : '1);
        cyc++;
        if (cyc > 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    initial begin
        void'($urandom(58220));
        repeat (8) @(negedge clk);
        check({rsp_valid, err_pulse, cmd_ready, refresh, tracking, err_ev}, 36'h600);
        check(setpoint, 36'h0);
        srst = 1'b0;
        q(vsl_pkg::CMD_Q_UPPER, vsl_pkg::NOM_MAX_MV);
        q(vsl_pkg::CMD_Q_LOWER, 32'sh0);
        s(vsl_pkg::CMD_SET_LOWER, 32'sd1000, 1'b1);
        s(vsl_pkg::CMD_SET_UPPER, -32'sd1000, 1'b1);
        s(vsl_pkg::CMD_SET_UPPER, 32'sd60001000, 1'b1);
        s(vsl_pkg::CMD_SET_POINT, 32'sd5000400, 1'b0);
        s(vsl_pkg::CMD_SET_UPPER, 32'sd4999000, 1'b1);
        s(vsl_pkg::CMD_SET_ALIAS, 32'sd50000000, 1'b0);
        q(vsl_pkg::CMD_Q_ALIAS, 32'sd50000);
        s(vsl_pkg::CMD_SET_POINT, 32'sd50000500, 1'b1);
        s(vsl_pkg::CMD_SET_LOWER, 32'sd5000000, 1'b0);
        s(vsl_pkg::CMD_SET_POINT, 32'sd4999000, 1'b1);
        q(vsl_pkg::CMD_Q_POINT, 32'sd5000);
        vsl_host_model_i.idle();
        check(err_ev, 36'h4);
        err_clear = 1'b1;
        @(negedge clk);
        err_clear = 1'b0;
        check(err_ev, 36'h0);
        ext_ctrl = 1'b1;
        s(vsl_pkg::CMD_SET_POINT, 32'sd4000000, 1'b0);
        q(vsl_pkg::CMD_Q_POINT, 32'sd4000);
        vsl_host_model_i.idle();
        ext_ctrl = 1'b0;
        $display("limits test done");
        vsl_host_model_i.send(vsl_pkg::CMD_TRACK_ON, 32'sh0);
        meas(32'sd1000);
        meas(32'sd3000);
        meas(-32'sd500);
        q(vsl_pkg::CMD_Q_PEAK, 32'sd3000);
        q(vsl_pkg::CMD_Q_FLOOR, -32'sd500);
        meas(32'sd99000);
        q(vsl_pkg::CMD_Q_MEAS, vsl_pkg::MEAS_OVF_CODE);
        q(vsl_pkg::CMD_Q_PEAK, vsl_pkg::PEAK_OVF_CODE);
        meas(-32'sd20000);
        q(vsl_pkg::CMD_Q_MEAS, -vsl_pkg::MEAS_OVF_CODE);
        q(vsl_pkg::CMD_Q_FLOOR, vsl_pkg::FLOOR_OVF_CODE);
        meas(32'sd1234);
        vsl_host_model_i.send(vsl_pkg::CMD_TRACK_RST, 32'sh0);
        q(vsl_pkg::CMD_Q_PEAK, 32'sd1234);
        q(vsl_pkg::CMD_Q_FLOOR, 32'sd1234);
        vsl_host_model_i.send(vsl_pkg::CMD_TRACK_OFF, 32'sh0);
        meas(32'sd777);
        q(vsl_pkg::CMD_Q_MEAS, 32'sd776);
        q(vsl_pkg::CMD_Q_PEAK, 32'sd1234);
        $display("tracking test done");
        for (int ms = 1; ms <= 2; ms++) begin
            vsl_host_model_i.send(vsl_pkg::CMD_WAIT, ms);
            n = 0;
            fork
                q(vsl_pkg::CMD_Q_POINT, 32'sd4000);
                begin
                    @(negedge clk);
                    while (cmd_ready === 1'b0 && n < 100) begin
                        check(refresh, 36'h0);
                        n++;
                        @(negedge clk);
                    end
                end
            join
            check(36'(n), 36'(ms * CYC + 1));
        end
        $display("wait test done");
        sp = 32'sd4000;
        for (int i = 0; i < 8; i++) begin
            uv = $urandom_range(70000000);
            ev = (uv + 32'sd500) / 32'sd1000;
            bad = (ev < 32'sd5000) || (ev > 32'sd50000);
            if (!bad) sp = ev;
            s(vsl_pkg::CMD_SET_POINT, uv, bad);
            q(vsl_pkg::CMD_Q_POINT, sp);
        end
        vsl_host_model_i.idle();
        repeat (3) @(negedge clk);
        check(setpoint, sp);
        $display("random setpoint test done");
        end_of_test();
    end
endmodule
`default_nettype wire

// ===== vsl_core.sv
// Voltage setpoint, soft limits, extreme tracking and wait delay block.
// Assumes decoded commands from a front-end parser, one per accepted cycle,
// and a measured output voltage in signed millivolts from the measuring path.
//
// Summary of operation
// [R1] Upper limit accepted only between present setpoint and nominal maximum.
// [R2] Lower limit accepted only between zero and present setpoint.
// [R3] Setpoint accepted only between lower and upper limits.
// [R4] Rejected value leaves storage unchanged, pulses error, sets error bit 2.
// [R5] Accepted voltage values are rounded to one millivolt before storing.
// [R6] Legacy alias sets upper limit; its query answers in upper limit format.
// [R7] Lower limit is ignored while the external analog control drives voltage.
// [R8] While tracking is on each measurement updates peak and floor records, unless a tracking reset is taken in the same cycle.
// [R9] Measurement above range while tracking makes peak report positive code.
// [R10] Measurement below range while tracking makes floor report negative code.
// [R11] Tracking reset loads the extreme records from the present measurement.
// [R12] Measured query returns the momentary value at 2 mV resolution.
// [R13] Measured value out of range is answered with the signed overflow code.
// [R14] Wait inserts a 1 ms to 65535 ms delay between chained commands.
// [R15] During a wait no command is taken and display refresh is held off.
// [R16] Chained commands are executed strictly in the order received.
// [R17] Reset clears setpoint and lower limit, sets upper limit to nominal.
// [R18] Wait counts whole milliseconds; commands resume the cycle after expiry.
`timescale 1ns/1ps
`default_nettype none
module vsl_core #(
    parameter int unsigned CYC_PER_MS = vsl_pkg::CYC_PER_MS
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic cmd_valid_i,
    input wire logic [3:0] cmd_code_i,
    input wire logic signed [31:0] cmd_value_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output logic [3:0] rsp_code_o,
    output logic signed [31:0] rsp_value_o,
    output logic err_pulse_o,
    input wire logic err_clear_i,
    output logic [7:0] cmd_error_events_o,
    input wire logic ext_volt_ctrl_i,
    input wire logic meas_valid_i,
    input wire logic signed [31:0] meas_mv_i,
    output logic display_refresh_o,
    output logic [31:0] volt_setpoint_o,
    output logic extreme_tracking_o
);
    typedef enum logic [0:0] {
        VSL_RUN = 1'b0,
        VSL_WAIT = 1'b1
    } vsl_state_type;

    vsl_state_type state_r;
    logic signed [31:0] upper_volt_limit_r;
    logic signed [31:0] lower_volt_limit_r;
    logic signed [31:0] setpoint_r;
    logic signed [31:0] peak_volt_record_r;
    logic signed [31:0] floor_volt_record_r;
    logic peak_ovf_r;
    logic floor_ovf_r;
    logic signed [31:0] meas_last_r;
    logic meas_over_r;
    logic meas_under_r;
    logic signed [31:0] rounded_mv;
    logic take;
    logic is_set;
    logic accept;
    logic reject;
    logic wait_done;
    logic meas_over;
    logic meas_under;

    vsl_round_mv u_round (
        .uv_i(cmd_value_i),
        .mv_o(rounded_mv)
    );

    vsl_ms_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_timer (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .start_i(take && (cmd_code_i == vsl_pkg::CMD_WAIT)),
        .ms_i(cmd_value_i[15:0]),
        .done_o(wait_done)
    );

    // One command per handshake, in arrival order
    assign take = cmd_valid_i && cmd_ready_o; // [R16]
    assign is_set = (cmd_code_i == vsl_pkg::CMD_SET_UPPER) ||
                    (cmd_code_i == vsl_pkg::CMD_SET_ALIAS) ||
                    (cmd_code_i == vsl_pkg::CMD_SET_LOWER) ||
                    (cmd_code_i == vsl_pkg::CMD_SET_POINT);
    assign meas_over = meas_mv_i > vsl_pkg::MEAS_MAX_MV;
    assign meas_under = meas_mv_i < vsl_pkg::MEAS_MIN_MV;

    // Range check of the rounded value against the present settings
    always_comb begin
        unique case (cmd_code_i)
            vsl_pkg::CMD_SET_UPPER, vsl_pkg::CMD_SET_ALIAS: begin
                accept = (rounded_mv >= setpoint_r) &&
                         (rounded_mv <= vsl_pkg::NOM_MAX_MV); // [R1] [R6]
            end
            vsl_pkg::CMD_SET_LOWER: begin
                accept = (rounded_mv >= vsl_pkg::ZERO_MV) &&
                         (rounded_mv <= setpoint_r); // [R2]
            end
            vsl_pkg::CMD_SET_POINT: begin
                accept = (rounded_mv >= vsl_pkg::ZERO_MV) &&
                         (ext_volt_ctrl_i || rounded_mv >= lower_volt_limit_r) && // [R7]
                         (rounded_mv <= upper_volt_limit_r); // [R3]
            end
            default: begin
                accept = 1'b0;
            end
        endcase
    end

    assign reject = take && is_set && !accept;

    // Stored settings, written only with an accepted, rounded value
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            upper_volt_limit_r <= vsl_pkg::NOM_MAX_MV; // [R17]
            lower_volt_limit_r <= vsl_pkg::ZERO_MV;
            setpoint_r <= vsl_pkg::ZERO_MV;
        end else if (take && accept) begin
            unique case (cmd_code_i)
                vsl_pkg::CMD_SET_UPPER, vsl_pkg::CMD_SET_ALIAS: begin
                    upper_volt_limit_r <= rounded_mv; // [R5] [R6]
                end
                vsl_pkg::CMD_SET_LOWER: begin
                    lower_volt_limit_r <= rounded_mv; // [R5]
                end
                vsl_pkg::CMD_SET_POINT: begin
                    setpoint_r <= rounded_mv; // [R5]
                end
                default: begin
                end
            endcase
        end
    end

    // Error pulse and sticky limit error bit; a new set beats a clear
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            err_pulse_o <= 1'b0;
            cmd_error_events_o <= vsl_pkg::ERR_RESET;
        end else begin
            err_pulse_o <= reject; // [R4]
            if (reject) begin
                cmd_error_events_o[vsl_pkg::ERR_LIMIT_BIT] <= 1'b1; // [R4]
            end else if (err_clear_i) begin
                cmd_error_events_o <= vsl_pkg::ERR_RESET;
            end
        end
    end

    // Latest measurement and its range flags
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            meas_last_r <= vsl_pkg::ZERO_MV;
            meas_over_r <= 1'b0;
            meas_under_r <= 1'b0;
        end else if (meas_valid_i) begin
            meas_last_r <= meas_mv_i;
            meas_over_r <= meas_over;
            meas_under_r <= meas_under;
        end
    end

    // Tracking switch
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            extreme_tracking_o <= 1'b0;
        end else if (take && cmd_code_i == vsl_pkg::CMD_TRACK_ON) begin
            extreme_tracking_o <= 1'b1;
        end else if (take && cmd_code_i == vsl_pkg::CMD_TRACK_OFF) begin
            extreme_tracking_o <= 1'b0;
        end
    end

    // Peak and floor records with sticky overflow marks
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            peak_volt_record_r <= vsl_pkg::ZERO_MV;
            floor_volt_record_r <= vsl_pkg::ZERO_MV;
            peak_ovf_r <= 1'b0;
            floor_ovf_r <= 1'b0;
        end else if (take && cmd_code_i == vsl_pkg::CMD_TRACK_RST) begin
            peak_volt_record_r <= meas_last_r; // [R11]
            floor_volt_record_r <= meas_last_r; // [R11]
            peak_ovf_r <= meas_over_r;
            floor_ovf_r <= meas_under_r;
        end else if (extreme_tracking_o && meas_valid_i) begin
            if (meas_mv_i > peak_volt_record_r) begin
                peak_volt_record_r <= meas_mv_i; // [R8]
            end
            if (meas_mv_i < floor_volt_record_r) begin
                floor_volt_record_r <= meas_mv_i; // [R8]
            end
            if (meas_over) begin
                peak_ovf_r <= 1'b1; // [R9]
            end
            if (meas_under) begin
                floor_ovf_r <= 1'b1; // [R10]
            end
        end
    end

    // Query answers, one cycle after the command is taken
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rsp_valid_o <= 1'b0;
            rsp_code_o <= vsl_pkg::CMD_NONE;
            rsp_value_o <= vsl_pkg::ZERO_MV;
        end else begin
            rsp_valid_o <= 1'b0;
            if (take && !is_set) begin
                rsp_code_o <= cmd_code_i;
                unique case (cmd_code_i)
                    vsl_pkg::CMD_Q_UPPER: begin
                        rsp_valid_o <= 1'b1;
                        rsp_value_o <= upper_volt_limit_r;
                    end
                    vsl_pkg::CMD_Q_ALIAS: begin
                        rsp_valid_o <= 1'b1;
                        rsp_code_o <= vsl_pkg::CMD_Q_UPPER; // [R6]
                        rsp_value_o <= upper_volt_limit_r;
                    end
                    vsl_pkg::CMD_Q_LOWER: begin
                        rsp_valid_o <= 1'b1;
                        rsp_value_o <= lower_volt_limit_r;
                    end
                    vsl_pkg::CMD_Q_POINT: begin
                        rsp_valid_o <= 1'b1;
                        rsp_value_o <= setpoint_r;
                    end
                    vsl_pkg::CMD_Q_PEAK: begin
                        rsp_valid_o <= 1'b1;
                        rsp_value_o <= peak_ovf_r ? vsl_pkg::PEAK_OVF_CODE
                                                  : peak_volt_record_r; // [R9]
                    end
                    vsl_pkg::CMD_Q_FLOOR: begin
                        rsp_valid_o <= 1'b1;
                        rsp_value_o <= floor_ovf_r ? vsl_pkg::FLOOR_OVF_CODE
                                                   : floor_volt_record_r; // [R10]
                    end
                    vsl_pkg::CMD_Q_MEAS: begin
                        rsp_valid_o <= 1'b1;
                        if (meas_over_r) begin
                            rsp_value_o <= vsl_pkg::MEAS_OVF_CODE; // [R13]
                        end else if (meas_under_r) begin
                            rsp_value_o <= -vsl_pkg::MEAS_OVF_CODE; // [R13]
                        end else begin
                            rsp_value_o <= {meas_last_r[31:1], 1'b0}; // [R12]
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Wait sequencing: input blocked until the cycle after expiry
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_r <= VSL_RUN;
            cmd_ready_o <= 1'b1;
            display_refresh_o <= 1'b1;
        end else begin
            unique case (state_r)
                VSL_RUN: begin
                    if (take && cmd_code_i == vsl_pkg::CMD_WAIT) begin
                        state_r <= VSL_WAIT; // [R14]
                        cmd_ready_o <= 1'b0; // [R15]
                        display_refresh_o <= 1'b0; // [R15]
                    end
                end
                VSL_WAIT: begin
                    if (wait_done) begin
                        state_r <= VSL_RUN; // [R18]
                        cmd_ready_o <= 1'b1;
                        display_refresh_o <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Setpoint copy to the regulator
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            volt_setpoint_o <= 32'h0000_0000;
        end else begin
            volt_setpoint_o <= setpoint_r;
        end
    end

    // Setpoint stays at or below the upper limit, upper limit within nominal, lower not below zero
    limit_order_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R1]
        (setpoint_r <= upper_volt_limit_r) && (upper_volt_limit_r <= vsl_pkg::NOM_MAX_MV)
        && (lower_volt_limit_r >= vsl_pkg::ZERO_MV))
        else $error("soft limits out of order");

    // A rejected value changes nothing and raises the error
    reject_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R4]
        reject |=> $stable(setpoint_r) && $stable(upper_volt_limit_r)
        && $stable(lower_volt_limit_r) && err_pulse_o && cmd_error_events_o[2])
        else $error("rejected value not handled");

    // Lower limit set above the setpoint is never stored
    lower_range_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R2]
        take && cmd_code_i == vsl_pkg::CMD_SET_LOWER && rounded_mv > setpoint_r
        |=> lower_volt_limit_r == $past(lower_volt_limit_r))
        else $error("lower limit above setpoint stored");

    // Accepted setpoint is stored rounded
    point_store_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R5]
        take && cmd_code_i == vsl_pkg::CMD_SET_POINT && accept
        |=> setpoint_r == $past(rounded_mv) ##1 volt_setpoint_o == $past(rounded_mv, 2))
        else $error("setpoint not stored rounded");

    // Alias query answers in the upper limit format
    alias_fmt_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R6]
        take && cmd_code_i == vsl_pkg::CMD_Q_ALIAS
        |=> rsp_valid_o && rsp_code_o == vsl_pkg::CMD_Q_UPPER
        && rsp_value_o == upper_volt_limit_r)
        else $error("alias query format wrong");

    // Peak overflow is answered with the positive code
    peak_code_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R9]
        take && cmd_code_i == vsl_pkg::CMD_Q_PEAK && peak_ovf_r
        |=> rsp_value_o == 32'sh000f_423f)
        else $error("peak overflow code wrong");

    // Floor overflow is answered with the negative code
    floor_code_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R10]
        take && cmd_code_i == vsl_pkg::CMD_Q_FLOOR && floor_ovf_r
        |=> rsp_value_o == -32'sh0098_967f)
        else $error("floor overflow code wrong");

    // Tracking reset loads both records with one value
    track_reset_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R11]
        take && cmd_code_i == vsl_pkg::CMD_TRACK_RST
        |=> peak_volt_record_r == floor_volt_record_r && peak_volt_record_r == $past(meas_last_r))
        else $error("tracking reset not loaded");

    // Peak record never falls and floor never rises while tracking runs, except at a tracking reset
    peak_mono_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R8]
        extreme_tracking_o && meas_valid_i && !take
        |=> peak_volt_record_r >= $past(peak_volt_record_r)
        && floor_volt_record_r <= $past(floor_volt_record_r))
        else $error("extreme record moved wrongly");

    // Measured answer in range is on the 2 mV grid
    meas_grid_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R12]
        take && cmd_code_i == vsl_pkg::CMD_Q_MEAS && !meas_over_r && !meas_under_r
        |=> rsp_valid_o && !rsp_value_o[0])
        else $error("measured answer off grid");

    // A wait blocks input and display for at least two cycles
    wait_block_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R15]
        take && cmd_code_i == vsl_pkg::CMD_WAIT
        |=> (!cmd_ready_o && !display_refresh_o) [*2])
        else $error("wait did not block input");

    // Ready returns the cycle after the timer expires
    wait_resume_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R18]
        wait_done |=> cmd_ready_o && display_refresh_o)
        else $error("no resume after wait");
endmodule
`default_nettype wire

// ===== vsl_host_model.sv
// Host model: issues one decoded command at a time on the command port.
// Assumes the bench calls send and idle; the bench owns the clock.
`timescale 1ns/1ps
`default_nettype none
module vsl_host_model (
    input wire logic ref_clk_i,
    input wire logic cmd_ready_i,
    output logic cmd_valid_o,
    output logic [3:0] cmd_code_o,
    output logic signed [31:0] cmd_value_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_code_o = 4'h0;
        cmd_value_o = 32'sh0;
    end
    // Present a command, hold it until taken; calls chain back to back
    task automatic send(input logic [3:0] code, input logic signed [31:0] val);
        @(negedge ref_clk_i);
        cmd_valid_o = 1'b1;
        cmd_code_o = code;
        cmd_value_o = val;
        @(posedge ref_clk_i);
        while (cmd_ready_i !== 1'b1) @(posedge ref_clk_i);
    endtask
    // Release the port; stale fields inverted so they never look meaningful
    task automatic idle();
        @(negedge ref_clk_i);
        cmd_valid_o = 1'b0;
        cmd_code_o = ~cmd_code_o;
        cmd_value_o = ~cmd_value_o;
    endtask
endmodule
`default_nettype wire

// ===== vsl_ms_timer.sv
// Millisecond wait timer: counts a loaded number of milliseconds from a
// divided tick and pulses done once. Assumes a start only while idle.
`timescale 1ns/1ps
`default_nettype none
module vsl_ms_timer #(
    parameter int unsigned CYC_PER_MS = vsl_pkg::CYC_PER_MS
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic start_i,
    input wire logic [15:0] ms_i,
    output logic done_o
);
    logic [31:0] tick_cnt_r;
    logic [15:0] ms_left_r;
    logic busy_r;
    logic tick;

    assign tick = busy_r && (tick_cnt_r == 32'(CYC_PER_MS - 1));

    // Cycle divider making the millisecond tick
    always_ff @(posedge ref_clk_i) begin
        if (srst_i || start_i || tick) begin
            tick_cnt_r <= 32'h0000_0000;
        end else if (busy_r) begin
            tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
        end
    end

    // Millisecond count; a zero request still waits the least step
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ms_left_r <= 16'h0000;
            busy_r <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                ms_left_r <= (ms_i < vsl_pkg::WAIT_MIN_MS) ? vsl_pkg::WAIT_MIN_MS : ms_i;
                busy_r <= 1'b1;
            end else if (tick) begin
                ms_left_r <= ms_left_r - 16'h0001;
                if (ms_left_r == 16'h0001) begin
                    busy_r <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== vsl_pkg.sv
// Package for the voltage setpoint, soft limit and extreme-value block.
// Assumes voltages travel as signed millivolt integers, 32 bits wide, except set command values, which are microvolt entries.
package vsl_pkg;

    // Data width of every voltage value and answer
    localparam int unsigned VAL_W = 32;

    // Command codes on the decoded command port
    localparam logic [3:0] CMD_NONE = 4'h0;
    localparam logic [3:0] CMD_SET_UPPER = 4'h1;
    localparam logic [3:0] CMD_SET_ALIAS = 4'h2;
    localparam logic [3:0] CMD_SET_LOWER = 4'h3;
    localparam logic [3:0] CMD_SET_POINT = 4'h4;
    localparam logic [3:0] CMD_Q_UPPER = 4'h5;
    localparam logic [3:0] CMD_Q_ALIAS = 4'h6;
    localparam logic [3:0] CMD_Q_LOWER = 4'h7;
    localparam logic [3:0] CMD_Q_POINT = 4'h8;
    localparam logic [3:0] CMD_Q_PEAK = 4'h9;
    localparam logic [3:0] CMD_Q_FLOOR = 4'ha;
    localparam logic [3:0] CMD_Q_MEAS = 4'hb;
    localparam logic [3:0] CMD_TRACK_ON = 4'hc;
    localparam logic [3:0] CMD_TRACK_OFF = 4'hd;
    localparam logic [3:0] CMD_TRACK_RST = 4'he;
    localparam logic [3:0] CMD_WAIT = 4'hf;

    // Voltage range and reset values in millivolts
    localparam logic signed [31:0] NOM_MAX_MV = 32'sh0000_ea60;
    localparam logic signed [31:0] ZERO_MV = 32'sh0000_0000;
    localparam logic signed [31:0] MEAS_MIN_MV = -32'sh0000_4000;
    localparam logic signed [31:0] MEAS_MAX_MV = 32'sh0001_7ffc;

    // Overflow codes placed in answers
    localparam logic signed [31:0] PEAK_OVF_CODE = 32'sh000f_423f;
    localparam logic signed [31:0] FLOOR_OVF_CODE = -32'sh0098_967f;
    localparam logic signed [31:0] MEAS_OVF_CODE = 32'sh000f_423f;

    // Rounding of microvolt entry to the millivolt step
    localparam logic signed [31:0] UV_PER_MV = 32'sh0000_03e8;
    localparam logic signed [31:0] UV_HALF_STEP = 32'sh0000_01f4;

    // Command error event register layout
    localparam int unsigned ERR_W = 8;
    localparam int unsigned ERR_LIMIT_BIT = 2;
    localparam logic [7:0] ERR_RESET = 8'h00;

    // Wait timing: one millisecond in clock cycles at 40 MHz
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned MS_PERIOD_NS = 1000000;
    localparam int unsigned CYC_PER_MS = MS_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [15:0] WAIT_MIN_MS = 16'h0001;

endpackage

// ===== vsl_round_mv.sv
// Rounds a signed microvolt entry to the nearest millivolt, half away from zero.
// Purely combinational; the caller registers the result where needed.
`timescale 1ns/1ps
`default_nettype none
module vsl_round_mv (
    input wire logic signed [31:0] uv_i,
    output logic signed [31:0] mv_o
);
    // Bias by half a step toward the sign, then truncate
    always_comb begin
        if (uv_i < 32'sh0000_0000) begin
            mv_o = (uv_i - vsl_pkg::UV_HALF_STEP) / vsl_pkg::UV_PER_MV;
        end else begin
            mv_o = (uv_i + vsl_pkg::UV_HALF_STEP) / vsl_pkg::UV_PER_MV;
        end
    end
endmodule
`default_nettype wire
